/* File: dpsf_host.sv */
// Host controller driving one port of the dual-port semaphore flag space
//
// Function
// RULE_01: Eight flags live apart from the RAM array; host addresses only them.
// RULE_02: Flags are active low: write zero to request, one to release.
// RULE_03: Flag space reached with select low plus ordinary SRAM address and controls.
// RULE_04: Device uses only the three low address bits to pick a flag.
// RULE_05: Device samples only data bit zero on a flag write.
// RULE_06: Zero to free flag: writer reads zero, other side reads one.
// RULE_07: Owner writing one frees flag unless the other side is pending.
// RULE_08: Non-owner zero waits in its request latch until flag freed.
// RULE_09: Flag read drives the value onto every data bit.
// RULE_10: Read value latched while select and output enable both stay active.
// RULE_11: Between polling reads, select or output enable must go inactive.
// RULE_12: Acquire is write zero then read back; never read first.
// RULE_13: Request on owned flag: latch holds zero, read returns one.
// RULE_14: After failed request keep reading or write one to withdraw.
// RULE_15: First latch showing zero owns the flag until it writes one.
// RULE_16: Pending request takes ownership at once when owner writes one.
// RULE_17: Competing requests: exactly one wins, earlier or arbitrary.
// RULE_18: At power-up software writes one to all eight flags.
// RULE_19: Array chip select stays high while flag space is selected.
// RULE_20: Same-cycle requests in a clocked model get a deterministic tie-break.
`default_nettype none
module dpsf_host
   import dpsf_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire logic              cmd_valid,
   input  wire dpsf_cmd_t         cmd,
   input  wire logic [7:0]        poll_max,
   output logic                   cmd_ready,
   output logic                   done,
   output logic                   granted,
   output logic                   flag_value,
   output dpsf_pins_t             pins,
   input  wire logic [DATA_W-1:0] dq_in
);
   // ****************************************
   // Pin drive function
   // ****************************************
   function automatic dpsf_pins_t drive(input dpsf_state_t st, input logic wr, input logic val,
                                        input logic [IDX_W-1:0] idx);
      dpsf_pins_t p;
      p = PINS_RST;
      if (st != S_IDLE && st != S_GAP) begin
         p.space_sel_b = PIN_ACTIVE;                      // see RULE_03
         p.chip_sel_b  = PIN_IDLE;                        // see RULE_19
         p.addr        = {{(ADDR_W-IDX_W){1'b0}}, idx};   // see RULE_04
         if (st == S_ACC) begin
            if (wr) begin
               p.rw_b   = PIN_ACTIVE;
               p.dq_out = {{(DATA_W-1){1'b0}}, val};      // see RULE_05
               p.dq_oe  = 1'b1;
            end else begin
               p.oe_b = PIN_ACTIVE;
            end
         end
      end
      return p;
   endfunction

   // ****************************************
   // Read data synchroniser
   // ****************************************
   logic [DATA_W-1:0] dq_sync;

   dpsf_sync u_dpsf_sync (
      .clk   (clk),
      .rst_b (rst_b),
      .d_in  (dq_in),
      .d_out (dq_sync)
   );

   // ****************************************
   // Sequencer state
   // ****************************************
   dpsf_state_t      state_r,   state_nxt;
   dpsf_op_t         op_r,      op_nxt;
   logic [IDX_W-1:0] idx_r,     idx_nxt;
   logic             wr_r,      wr_nxt;
   logic             val_r,     val_nxt;
   logic             wd_r,      wd_nxt;
   logic [3:0]       cnt_r,     cnt_nxt;
   logic [7:0]       polls_r,   polls_nxt;
   logic             sample_r,  sample_nxt;
   logic             ready_r,   ready_nxt;
   logic             done_r,    done_nxt;
   logic             grant_r,   grant_nxt;
   logic             flag_r,    flag_nxt;
   dpsf_pins_t       pins_r,    pins_nxt;

   always_comb begin
      state_nxt  = state_r;
      op_nxt     = op_r;
      idx_nxt    = idx_r;
      wr_nxt     = wr_r;
      val_nxt    = val_r;
      wd_nxt     = wd_r;
      cnt_nxt    = cnt_r;
      polls_nxt  = polls_r;
      sample_nxt = sample_r;
      grant_nxt  = grant_r;
      flag_nxt   = flag_r;
      done_nxt   = 1'b0;
      case (state_r)
         S_IDLE: begin
            if (cmd_valid) begin
               op_nxt    = cmd.op;
               idx_nxt   = cmd.idx;
               wd_nxt    = 1'b0;
               polls_nxt = 8'h00;
               state_nxt = S_SETUP;
               // Acquire always opens with the write, never a read
               case (cmd.op)
                  OP_ACQUIRE: begin
                     wr_nxt  = 1'b1;
                     val_nxt = FLAG_TAKEN;                // see RULE_02, RULE_12
                  end
                  OP_RELEASE: begin
                     wr_nxt  = 1'b1;
                     val_nxt = FLAG_FREE;                 // see RULE_02
                  end
                  OP_INIT: begin
                     wr_nxt  = 1'b1;
                     val_nxt = FLAG_FREE;
                     idx_nxt = 3'h0;                      // see RULE_18
                  end
                  default: begin
                     wr_nxt  = 1'b0;
                     val_nxt = FLAG_FREE;
                  end
               endcase
            end
         end
         S_SETUP: begin
            cnt_nxt   = STROBE_CYC;
            state_nxt = S_ACC;
         end
         S_ACC: begin
            cnt_nxt = cnt_r - 4'h1;
            if (cnt_r == 4'h1) begin
               // Whole strobe covers the sync latency, so the value is settled
               sample_nxt = dq_sync[0];                   // see RULE_09
               state_nxt  = S_GAP;
            end
         end
         default: begin
            // Gap drops select and output enable so the next read relatches
            state_nxt = S_SETUP;                          // see RULE_11
            case (op_r)
               OP_READ: begin
                  flag_nxt  = sample_r;
                  done_nxt  = 1'b1;
                  state_nxt = S_IDLE;
               end
               OP_RELEASE: begin
                  done_nxt  = 1'b1;
                  state_nxt = S_IDLE;
               end
               OP_INIT: begin
                  if (idx_r == IDX_LAST) begin
                     done_nxt  = 1'b1;
                     state_nxt = S_IDLE;
                  end else begin
                     idx_nxt = idx_r + 3'h1;              // see RULE_18
                  end
               end
               default: begin
                  if (wr_r && !wd_r) begin
                     wr_nxt = 1'b0;                       // see RULE_12
                  end else if (wd_r) begin
                     grant_nxt = 1'b0;
                     flag_nxt  = FLAG_FREE;
                     done_nxt  = 1'b1;
                     state_nxt = S_IDLE;
                  end else if (sample_r == FLAG_TAKEN) begin
                     // Zero read back means this port owns the token
                     grant_nxt = 1'b1;                    // see RULE_06, RULE_15
                     flag_nxt  = FLAG_TAKEN;
                     done_nxt  = 1'b1;
                     state_nxt = S_IDLE;
                  end else if (polls_r < poll_max) begin
                     // Other side owns it; keep reading for a handover
                     polls_nxt = polls_r + 8'h01;         // see RULE_13, RULE_14, RULE_16
                  end else begin
                     // Withdraw, else a stale request could later seize the flag
                     wd_nxt  = 1'b1;                      // see RULE_14, RULE_08
                     wr_nxt  = 1'b1;
                     val_nxt = FLAG_FREE;
                  end
               end
            endcase
         end
      endcase
      ready_nxt = (state_nxt == S_IDLE);
      pins_nxt  = drive(state_nxt, wr_nxt, val_nxt, idx_nxt);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r  <= S_IDLE;
         op_r     <= OP_READ;
         idx_r    <= 3'h0;
         wr_r     <= 1'b0;
         val_r    <= 1'b1;
         wd_r     <= 1'b0;
         cnt_r    <= 4'h0;
         polls_r  <= 8'h00;
         sample_r <= 1'b1;
         ready_r  <= 1'b1;
         done_r   <= 1'b0;
         grant_r  <= 1'b0;
         flag_r   <= 1'b1;
         pins_r   <= PINS_RST;
      end else begin
         state_r  <= state_nxt;
         op_r     <= op_nxt;
         idx_r    <= idx_nxt;
         wr_r     <= wr_nxt;
         val_r    <= val_nxt;
         wd_r     <= wd_nxt;
         cnt_r    <= cnt_nxt;
         polls_r  <= polls_nxt;
         sample_r <= sample_nxt;
         ready_r  <= ready_nxt;
         done_r   <= done_nxt;
         grant_r  <= grant_nxt;
         flag_r   <= flag_nxt;
         pins_r   <= pins_nxt;
      end
   end

   assign cmd_ready  = ready_r;
   assign done       = done_r;
   assign granted    = grant_r;
   assign flag_value = flag_r;
   assign pins       = pins_r;
endmodule
`default_nettype wire

/* File: dpsf_pkg.sv */
// Constants, types and pin helpers for the semaphore flag host controller
`default_nettype none
package dpsf_pkg;
   // ****************************************
   // Widths and counts
   // ****************************************
   localparam int ADDR_W    = 17;
   localparam int DATA_W    = 8;
   localparam int IDX_W     = 3;
   localparam int FLAG_CNT  = 8;
   localparam logic [IDX_W-1:0] IDX_LAST = 3'h7;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 100;
   localparam int T_STROBE_NS   = 300;
   // Least time: round up, at least one cycle
   localparam int STROBE_CYC_I  = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] STROBE_CYC = 4'(STROBE_CYC_I < 1 ? 1 : STROBE_CYC_I);
   localparam int SYNC_STAGES   = 2;

   // ****************************************
   // Pin levels
   // ****************************************
   localparam logic FLAG_TAKEN = 1'b0;
   localparam logic FLAG_FREE  = 1'b1;
   localparam logic PIN_ACTIVE = 1'b0;
   localparam logic PIN_IDLE   = 1'b1;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      OP_READ    = 2'h0,
      OP_ACQUIRE = 2'h1,
      OP_RELEASE = 2'h2,
      OP_INIT    = 2'h3
   } dpsf_op_t;

   typedef enum logic [1:0] {
      S_IDLE  = 2'b00,
      S_SETUP = 2'b01,
      S_ACC   = 2'b10,
      S_GAP   = 2'b11
   } dpsf_state_t;

   typedef struct packed {
      dpsf_op_t         op;
      logic [IDX_W-1:0] idx;
   } dpsf_cmd_t;

   typedef struct packed {
      logic              space_sel_b;
      logic              chip_sel_b;
      logic              rw_b;
      logic              oe_b;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dq_out;
      logic              dq_oe;
   } dpsf_pins_t;

   localparam dpsf_pins_t PINS_RST = '{space_sel_b: 1'b1, chip_sel_b: 1'b1, rw_b: 1'b1, oe_b: 1'b1,
                                       addr: 17'h00000, dq_out: 8'h00, dq_oe: 1'b0};
endpackage
`default_nettype wire

/* File: dpsf_sync.sv */
// Two-stage synchroniser for the read data pins
`default_nettype none
module dpsf_sync
   import dpsf_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire logic [DATA_W-1:0] d_in,
   output logic      [DATA_W-1:0] d_out
);
   logic [DATA_W-1:0] meta_r;
   logic [DATA_W-1:0] meta_nxt;
   logic [DATA_W-1:0] sync_r;
   logic [DATA_W-1:0] sync_nxt;

   always_comb begin
      meta_nxt = d_in;
      sync_nxt = meta_r;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_r <= 8'h00;
         sync_r <= 8'h00;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
      end
   end

   assign d_out = sync_r;
endmodule
`default_nettype wire

/* File: dpsf_host_sva.sv */
// Port checker for the semaphore flag host controller
`default_nettype none
module dpsf_host_chk
   import dpsf_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire logic              cmd_valid,
   input  wire dpsf_cmd_t         cmd,
   input  wire logic [7:0]        poll_max,
   input  wire logic              cmd_ready,
   input  wire logic              done,
   input  wire logic              granted,
   input  wire logic              flag_value,
   input  wire dpsf_pins_t        pins,
   input  wire logic [DATA_W-1:0] dq_in
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire logic take = cmd_valid && cmd_ready;
   // ****
   // Pin and command timing
   // ****
   property p_cs; pins.chip_sel_b == PIN_IDLE; endproperty
   a_cs: assert property (p_cs) else $error("array select low");
   property p_addr; !pins.space_sel_b |-> pins.addr[16:3] == 14'h0000; endproperty
   a_addr: assert property (p_addr) else $error("high address set");
   property p_wdat; !pins.rw_b |-> pins.dq_out[7:1] == 7'h00 && !pins.space_sel_b; endproperty
   a_wdat: assert property (p_wdat) else $error("bad write data");
   property p_rd; $fell(pins.oe_b) |-> (!pins.oe_b && pins.rw_b)[*3] ##1 pins.oe_b; endproperty
   a_rd: assert property (p_rd) else $error("read strobe length");
   property p_wr; $fell(pins.rw_b) |-> (!pins.rw_b && pins.dq_oe)[*3] ##1 pins.rw_b; endproperty
   a_wr: assert property (p_wr) else $error("write strobe length");
   property p_gap; !pins.oe_b ##1 pins.oe_b |-> pins.space_sel_b; endproperty
   a_gap: assert property (p_gap) else $error("no gap after read");
   property p_setup; $fell(pins.space_sel_b) |-> pins.oe_b && pins.rw_b; endproperty
   a_setup: assert property (p_setup) else $error("strobe without setup");
   property p_rlat; take && cmd.op == OP_READ |=> !done[*5] ##1 done && cmd_ready; endproperty
   a_rlat: assert property (p_rlat) else $error("read latency");
   property p_acq; take && cmd.op == OP_ACQUIRE |-> ##2 !pins.rw_b && pins.oe_b; endproperty
   a_acq: assert property (p_acq) else $error("acquire read first");
   property p_grant; $rose(granted) |-> done && !flag_value; endproperty
   a_grant: assert property (p_grant) else $error("grant without low flag");
   c_grant: cover property ($rose(granted));
   c_fail: cover property (done && !granted && flag_value);
   c_init: cover property (take && cmd.op == OP_INIT);
endmodule
bind dpsf_host dpsf_host_chk u_dpsf_host_chk (.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd(cmd),
   .poll_max(poll_max), .cmd_ready(cmd_ready), .done(done), .granted(granted), .flag_value(flag_value),
   .pins(pins), .dq_in(dq_in));
`default_nettype wire

/* File: dpsf_dev_model.sv */
// Behavioural two-port flag device facing the host
`default_nettype none
module dpsf_dev_model
   import dpsf_pkg::*;
(
   input  wire dpsf_pins_t        l_pins,
   input  wire dpsf_pins_t        r_pins,
   output logic      [DATA_W-1:0] l_q,
   output logic      [DATA_W-1:0] r_q
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****
   // Request latches, apart from any array
   // ****
   logic [FLAG_CNT-1:0] req_l = '0;
   logic [FLAG_CNT-1:0] req_r = '0;
   logic [1:0]          own [FLAG_CNT];
   logic                lat_l = 1'b0;
   logic                lat_r = 1'b0;
   wire logic l_wr = !l_pins.space_sel_b && l_pins.chip_sel_b && !l_pins.rw_b;
   wire logic r_wr = !r_pins.space_sel_b && r_pins.chip_sel_b && !r_pins.rw_b;
   wire logic l_rd = !l_pins.space_sel_b && l_pins.chip_sel_b && !l_pins.oe_b;
   wire logic r_rd = !r_pins.space_sel_b && r_pins.chip_sel_b && !r_pins.oe_b;
   // Power-up state is junk: only both sides writing one frees it
   initial for (int i = 0; i < FLAG_CNT; i++) own[i] = 2'h1;
   // Owner code 1 left, 2 right, 0 free
   function automatic logic [1:0] res(logic [1:0] o, logic ql, logic qr);
      if (o == 2'h1 && ql) o = 2'h0;
      if (o == 2'h2 && qr) o = 2'h0;
      if (o == 2'h0) o = !ql ? 2'h1 : (!qr ? 2'h2 : 2'h0); // Left wins a tie
      return o;
   endfunction
   always @(posedge l_wr) begin
      req_l[l_pins.addr[2:0]] = l_pins.dq_out[0];
      own[l_pins.addr[2:0]] = res(own[l_pins.addr[2:0]], req_l[l_pins.addr[2:0]], req_r[l_pins.addr[2:0]]);
   end
   always @(posedge r_wr) begin
      req_r[r_pins.addr[2:0]] = r_pins.dq_out[0];
      own[r_pins.addr[2:0]] = res(own[r_pins.addr[2:0]], req_l[r_pins.addr[2:0]], req_r[r_pins.addr[2:0]]);
   end
   always @(posedge l_rd) lat_l = own[l_pins.addr[2:0]] != 2'h1;
   always @(posedge r_rd) lat_r = own[r_pins.addr[2:0]] != 2'h2;
   // Idle bus shows the inverse so a stale value never passes
   assign l_q = l_rd ? {DATA_W{lat_l}} : ~{DATA_W{lat_l}};
   assign r_q = r_rd ? {DATA_W{lat_r}} : ~{DATA_W{lat_r}};
endmodule
`default_nettype wire

/* File: tb_dual_port_semaphore_flags.sv */
// Self-checking bench for the semaphore flag host controller
`default_nettype none
module tb_dual_port_semaphore_flags
   import dpsf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_b, cmd_valid, cmd_ready, done, granted, flag_value;
   logic [7:0] poll_max, q;
   logic [DATA_W-1:0] l_q, r_q;
   dpsf_cmd_t cmd;
   dpsf_pins_t pins, r_pins;
   int error_cnt = 0;
   int checks_done = 0;
   int cyc_cnt = 0;
   dpsf_host u_dpsf_host (.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd(cmd), .poll_max(poll_max),
      .cmd_ready(cmd_ready), .done(done), .granted(granted), .flag_value(flag_value), .pins(pins), .dq_in(l_q));
   dpsf_dev_model u_dpsf_dev_model (.l_pins(pins), .r_pins(r_pins), .l_q(l_q), .r_q(r_q));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // ****
   // Checks and drivers
   // ****
   task automatic chk_bit(logic got, logic exp, string m);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t %s", $time, m);
      end
   endtask
   task automatic chk_byte(logic [7:0] got, logic [7:0] exp, string m);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t %s %h", $time, m, got);
      end
   endtask
   task automatic run_cmd(dpsf_op_t op, logic [2:0] idx, logic [7:0] pm);
      int n;
      cmd_valid = 1'b1;
      cmd = '{op: op, idx: idx};
      poll_max = pm;
      @(posedge clk);
      #1 cmd_valid = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 400) begin
         @(posedge clk);
         #1 n++;
      end
      chk_bit(done, 1'b1, "no done");
   endtask
   // Far port; high address and data bits are junk the device must ignore
   task automatic r_acc(logic wr, logic [2:0] idx, logic v);
      r_pins.addr = {14'h3FFF, idx};
      r_pins.dq_out = {7'h55, v};
      r_pins.space_sel_b = 1'b0;
      @(posedge clk);
      #1 r_pins.rw_b = !wr;
      r_pins.oe_b = wr;
      r_pins.dq_oe = wr;
      repeat (3) @(posedge clk);
      q = r_q;
      #1 r_pins = PINS_RST;
      @(posedge clk);
      #1;
   endtask
   // ****
   // Scenarios
   // ****
   task automatic t_init();
      run_cmd(OP_INIT, 3'h0, 8'h00);
      for (int i = 0; i < FLAG_CNT; i++) r_acc(1'b1, 3'(i), 1'b1);
      for (int i = 0; i < FLAG_CNT; i++) begin
         r_acc(1'b0, 3'(i), 1'b0);
         chk_byte(q, 8'hFF, "flag not free");
      end
      run_cmd(OP_READ, 3'h7, 8'h00);
      chk_bit(flag_value, 1'b1, "host flag not free");
   endtask
   task automatic t_handover();
      run_cmd(OP_ACQUIRE, 3'h5, 8'h00);
      chk_bit(granted, 1'b1, "no grant");
      chk_bit(flag_value, 1'b0, "flag not low");
      r_acc(1'b1, 3'h5, 1'b0);
      r_acc(1'b0, 3'h5, 1'b0);
      chk_byte(q, 8'hFF, "far side not locked");
      run_cmd(OP_READ, 3'h5, 8'h00);
      chk_bit(flag_value, 1'b0, "lost token");
      run_cmd(OP_RELEASE, 3'h5, 8'h00);
      run_cmd(OP_READ, 3'h5, 8'h00);
      chk_bit(flag_value, 1'b1, "token not passed");
      r_acc(1'b0, 3'h5, 1'b0);
      chk_byte(q, 8'h00, "far side not owner");
      r_acc(1'b1, 3'h5, 1'b1);
      run_cmd(OP_ACQUIRE, 3'h5, 8'h00);
      chk_bit(granted, 1'b1, "freed flag not granted");
      run_cmd(OP_RELEASE, 3'h5, 8'h00);
   endtask
   task automatic t_withdraw();
      r_acc(1'b1, 3'h2, 1'b0);
      run_cmd(OP_ACQUIRE, 3'h2, 8'h01);
      chk_bit(granted, 1'b0, "granted while owned");
      chk_bit(flag_value, 1'b1, "bad flag after try");
      r_acc(1'b1, 3'h2, 1'b1);
      run_cmd(OP_READ, 3'h2, 8'h00);
      chk_bit(flag_value, 1'b1, "request not withdrawn");
   endtask
   task automatic tally_and_finish();
      $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Ceiling well above the roughly 230 cycles the scenarios need
   always @(posedge clk) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 3000) begin
         error_cnt++;
         $display("MISMATCH t=%0t timeout", $time);
         tally_and_finish();
      end
   end
   initial begin
      rst_b = 1'b0;
      cmd_valid = 1'b0;
      cmd = '{op: OP_READ, idx: 3'h0};
      poll_max = 8'h00;
      r_pins = PINS_RST;
      repeat (2) @(posedge clk);
      #1 rst_b = 1'b1;
      chk_bit(cmd_ready, 1'b1, "not ready after reset");
      t_init();
      t_handover();
      t_withdraw();
      tally_and_finish();
   end
endmodule
`default_nettype wire
